//--- include/scr_defines.svh
// Constants for scan configuration load and serial readback
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// ==========================================================
// Timing
`define SCR_CLK_PERIOD_NS 20
`define SCR_PROG_MIN_NS   300
`define SCR_PROG_MIN_CYC  ((`SCR_PROG_MIN_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_CLEAR_NS      1000
`define SCR_CLEAR_CYC     ((`SCR_CLEAR_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_DONE_TAIL     3

// ==========================================================
// Test port instruction register
`define SCR_IR_W          3
`define SCR_IR_RESET      3'h7
`define SCR_IR_CONFIG     3'h5

// ==========================================================
// Configuration memory and stream layout
`define SCR_LEN_W         24
`define SCR_FRAME_BITS    16
`define SCR_FRAMES        4
`define SCR_MEM_BITS      64
`define SCR_IDX_W         6
`define SCR_DUMMY_BITS    5
`define SCR_CHECK_BITS    4
`define SCR_FIRST_HIGH    2
`define SCR_LAST_HIGH     7
`define SCR_CRC_W         11
`define SCR_CRC_POLY      11'h205

`endif

//--- include/scr_pkg.sv
// Types shared by the scan configuration and readback logic
package scr_pkg;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } scr_tap_state_type;

    typedef enum logic [2:0] {
        LD_CLEAR, LD_WAIT, LD_LOAD, LD_DONE, LD_COMPLETE
    } scr_load_state_type;

    typedef enum logic [2:0] {
        RB_IDLE, RB_DUMMY, RB_START, RB_DATA, RB_CHECK, RB_END_START, RB_CRC, RB_LAST
    } scr_rb_state_type;

endpackage

//--- src/scr_tap_ctrl.sv
// Test access port state machine and instruction register
`timescale 1ns/10ps
`default_nettype none
`include "scr_defines.svh"

module scr_tap_ctrl (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      tckRise,
    input  wire logic                      tmsIn,
    input  wire logic                      tdiIn,
    output scr_pkg::scr_tap_state_type     tapState,
    output logic                           instrConfig,
    output logic                           tdoBit
);
    import scr_pkg::*;

    scr_tap_state_type        state_q;
    scr_tap_state_type        state_d;
    logic [`SCR_IR_W-1:0]     irShift_q;
    logic [`SCR_IR_W-1:0]     ir_q;

    always_comb
    begin
        case (state_q)
            TAP_RESET:    state_d = tmsIn ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:     state_d = tmsIn ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   state_d = tmsIn ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   state_d = tmsIn ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_d = tmsIn ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_d = tmsIn ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_d = tmsIn ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_d = tmsIn ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR:   state_d = tmsIn ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   state_d = tmsIn ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR:   state_d = tmsIn ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_d = tmsIn ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_d = tmsIn ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_d = tmsIn ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_d = tmsIn ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR:   state_d = tmsIn ? TAP_SEL_DR : TAP_IDLE;
            default:      state_d = TAP_RESET;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_q <= TAP_RESET;
        else if (tckRise)
            state_q <= state_d;
    end

    // ==========================================================
    // Instruction register, shifted in least significant bit first
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irShift_q <= `SCR_IR_RESET;
            ir_q      <= `SCR_IR_RESET;
        end
        else if (tckRise)
        begin
            if (state_q == TAP_RESET)
                ir_q <= `SCR_IR_RESET;
            else if (state_q == TAP_CAP_IR)
                irShift_q <= `SCR_IR_RESET;
            else if (state_q == TAP_SHIFT_IR)
                irShift_q <= {tdiIn, irShift_q[`SCR_IR_W-1:1]};
            else if (state_q == TAP_UPD_IR)
                ir_q <= irShift_q;
        end
    end

    assign tapState    = state_q;
    assign instrConfig = (ir_q == `SCR_IR_CONFIG);
    assign tdoBit      = (state_q == TAP_SHIFT_IR) ? irShift_q[0] : 1'b0;

endmodule
`default_nettype wire

//--- src/scr_config_readback.sv
// Scan-port configuration loader and serial configuration readback
`timescale 1ns/10ps
`default_nettype none
`include "scr_defines.svh"

module scr_config_readback (
    input  wire logic     clk_sys,
    input  wire logic     rst,
    input  wire logic     tck,
    input  wire logic     tms,
    input  wire logic     tdi,
    output logic          tdo,
    output logic          tdoOe,
    input  wire logic     programN,
    input  wire logic     initIn,
    output logic          initOut,
    output logic          initOe,
    output logic          done,
    output logic          cfgComplete,
    input  wire logic     readbackShiftClk,
    input  wire logic     readbackTrigger,
    output logic          readbackSerialOut,
    output logic          readbackActive
);
    import scr_pkg::*;

    localparam int PIN_TCK  = 0;
    localparam int PIN_TMS  = 1;
    localparam int PIN_TDI  = 2;
    localparam int PIN_INIT = 3;
    localparam int PIN_PROG = 4;

    // ==========================================================
    // Pin synchronisers
    logic [4:0]                 pinMeta_q;
    logic [4:0]                 pinSync_q;
    logic                       tckDly_q;
    logic                       tckRise;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // Reset to the idle pin levels, so no false TCK edge follows reset
            pinMeta_q <= 5'h1a;
            pinSync_q <= 5'h1a;
            tckDly_q  <= 1'b0;
        end
        else
        begin
            pinMeta_q <= {programN, initIn, tdi, tms, tck};
            pinSync_q <= pinMeta_q;
            tckDly_q  <= pinSync_q[PIN_TCK];
        end
    end

    // TCK is oversampled, so it must stay well below a quarter of clk_sys
    assign tckRise = pinSync_q[PIN_TCK] & ~tckDly_q;

    scr_tap_state_type          tapState;
    logic                       instrConfig;
    logic                       tdoBit;

    scr_tap_ctrl u_tap (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .tckRise     (tckRise),
        .tmsIn       (pinSync_q[PIN_TMS]),
        .tdiIn       (pinSync_q[PIN_TDI]),
        .tapState    (tapState),
        .instrConfig (instrConfig),
        .tdoBit      (tdoBit)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end
        else if (tckRise)
        begin
            tdo   <= tdoBit;
            tdoOe <= (tapState == TAP_SHIFT_IR) || (tapState == TAP_SHIFT_DR);
        end
    end

    // ==========================================================
    // Reconfigure request filter
    logic [4:0]                 progLowCnt_q;
    logic                       reconfigReq;

    always_ff @(posedge clk_sys)
    begin
        if (rst || pinSync_q[PIN_PROG])
            progLowCnt_q <= 5'h00;
        else if (progLowCnt_q != 5'h1f)
            progLowCnt_q <= progLowCnt_q + 5'h01;
    end

    assign reconfigReq = (progLowCnt_q == 5'(`SCR_PROG_MIN_CYC + 1));

    // ==========================================================
    // Load sequencer
    scr_load_state_type         ldState_q;
    logic [5:0]                 clearCnt_q;
    logic [`SCR_LEN_W-1:0]      tckCount_q;
    logic [`SCR_LEN_W-1:0]      lenCount_q;
    logic [4:0]                 lenBits_q;
    logic [`SCR_IDX_W:0]        wrIdx_q;
    logic [`SCR_MEM_BITS-1:0]   cfgMem_q;
    logic [1:0]                 tailCnt_q;
    logic                       memFull;
    logic                       doneCond;
    logic                       shiftData;

    assign memFull   = wrIdx_q[`SCR_IDX_W];
    assign doneCond  = memFull && (tckCount_q == lenCount_q);
    assign shiftData = tckRise && (tapState == TAP_SHIFT_DR) && instrConfig;

    always_ff @(posedge clk_sys)
    begin
        if (rst || reconfigReq)
        begin
            ldState_q  <= LD_CLEAR;
            clearCnt_q <= 6'h00;
            tailCnt_q  <= 2'h0;
        end
        else
        begin
            case (ldState_q)
                LD_CLEAR:
                begin
                    if (!pinSync_q[PIN_PROG])
                        clearCnt_q <= 6'h00;
                    else if (clearCnt_q == 6'(`SCR_CLEAR_CYC - 1))
                        ldState_q <= LD_WAIT;
                    else
                        clearCnt_q <= clearCnt_q + 6'h01;
                end
                LD_WAIT:
                begin
                    if (pinSync_q[PIN_INIT] && instrConfig)
                        ldState_q <= LD_LOAD;
                end
                LD_LOAD:
                begin
                    if (doneCond)
                        ldState_q <= LD_DONE;
                end
                LD_DONE:
                begin
                    if (tckRise)
                    begin
                        tailCnt_q <= tailCnt_q + 2'h1;
                        if (tailCnt_q == 2'(`SCR_DONE_TAIL - 1))
                            ldState_q <= LD_COMPLETE;
                    end
                end
                LD_COMPLETE:
                    ldState_q <= LD_COMPLETE;
                default:
                    ldState_q <= LD_CLEAR;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || ldState_q == LD_CLEAR || ldState_q == LD_WAIT)
            tckCount_q <= '0;
        else if (ldState_q == LD_LOAD && tckRise)
            tckCount_q <= tckCount_q + 24'h000001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || ldState_q == LD_CLEAR)
        begin
            lenCount_q <= '0;
            lenBits_q  <= 5'h00;
        end
        else if (ldState_q == LD_LOAD && shiftData && lenBits_q != 5'(`SCR_LEN_W))
        begin
            lenCount_q <= {lenCount_q[`SCR_LEN_W-2:0], pinSync_q[PIN_TDI]};
            lenBits_q  <= lenBits_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || ldState_q == LD_CLEAR)
        begin
            cfgMem_q <= '0;
            wrIdx_q  <= '0;
        end
        else if (ldState_q == LD_LOAD && shiftData && lenBits_q == 5'(`SCR_LEN_W) && !memFull)
        begin
            cfgMem_q[wrIdx_q[`SCR_IDX_W-1:0]] <= pinSync_q[PIN_TDI];
            wrIdx_q <= wrIdx_q + 7'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cfgComplete <= 1'b0;
        else
            cfgComplete <= (ldState_q == LD_COMPLETE) && !reconfigReq;
    end

    // Init is open drain: only ever pulled low, never driven high
    assign initOut = 1'b0;
    assign initOe  = (ldState_q == LD_CLEAR);
    assign done    = (ldState_q == LD_DONE) || (ldState_q == LD_COMPLETE);

    a_reconf_init: assert property (@(posedge clk_sys) disable iff (rst)
        reconfigReq |=> initOe [*2])
        else $error("init not held low after reconfigure request");
    a_wait_no_load: assert property (@(posedge clk_sys) disable iff (rst)
        (ldState_q == LD_WAIT && !pinSync_q[PIN_INIT]) |=> ldState_q != LD_LOAD)
        else $error("load started while init low");
    a_tck_counted: assert property (@(posedge clk_sys) disable iff (rst)
        (ldState_q == LD_LOAD && tckRise && !reconfigReq) |=> tckCount_q - $past(tckCount_q) == 24'h000001)
        else $error("TCK cycle not counted");
    a_done_exact: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(done) |-> $past(doneCond))
        else $error("done without full memory and matching count");
    a_tail_three: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(cfgComplete) |-> $past(tailCnt_q, 2) == 2'h2)
        else $error("complete before three clocks after done");
    c_load_done: cover property (@(posedge clk_sys) disable iff (rst) $rose(done));
    c_reconfig: cover property (@(posedge clk_sys) disable iff (rst) reconfigReq);

    // ==========================================================
    // Readback domain
    // Memory is frozen from complete until a reconfigure request clears it, so it is read here without a crossing
    logic                       rbRstMeta_q;
    logic                       rbRst_q;
    logic                       cplMeta_q;
    logic                       cplSync_q;
    scr_rb_state_type           rbState_q;
    logic [4:0]                 rbCnt_q;
    logic [1:0]                 rbFrame_q;
    logic [`SCR_CRC_W-1:0]      crc_q;
    logic                       streamBit;
    logic                       memBit;
    logic                       forced;

    function automatic logic isForced(input scr_rb_state_type st, input logic [1:0] fr, input logic [4:0] cnt);
        isForced = (st == RB_DATA) &&
                   ((fr == 2'h0 && cnt < 5'(`SCR_FIRST_HIGH)) ||
                    (fr == 2'(`SCR_FRAMES - 1) && cnt >= 5'(`SCR_FRAME_BITS - `SCR_LAST_HIGH)));
    endfunction

    always_ff @(posedge readbackShiftClk)
    begin
        rbRstMeta_q <= rst;
        rbRst_q     <= rbRstMeta_q;
        cplMeta_q   <= cfgComplete;
        cplSync_q   <= cplMeta_q;
    end

    assign memBit = cfgMem_q[{rbFrame_q, rbCnt_q[3:0]}];
    assign forced = isForced(rbState_q, rbFrame_q, rbCnt_q);

    always_comb
    begin
        case (rbState_q)
            RB_START, RB_END_START: streamBit = 1'b0;
            RB_DATA:                streamBit = forced ? 1'b1 : memBit;
            RB_CRC:                 streamBit = crc_q[`SCR_CRC_W-1];
            default:                streamBit = 1'b1;
        endcase
    end

    always_ff @(posedge readbackShiftClk)
    begin
        if (rbRst_q)
        begin
            rbState_q      <= RB_IDLE;
            rbCnt_q        <= 5'h00;
            rbFrame_q      <= 2'h0;
            readbackActive <= 1'b0;
        end
        else
        begin
            rbCnt_q <= rbCnt_q + 5'h01;
            case (rbState_q)
                RB_IDLE:
                begin
                    rbCnt_q <= 5'h00;
                    if (readbackTrigger && cplSync_q)
                    begin
                        rbState_q      <= RB_DUMMY;
                        rbFrame_q      <= 2'h0;
                        readbackActive <= 1'b1;
                    end
                end
                RB_DUMMY:
                    if (rbCnt_q == 5'(`SCR_DUMMY_BITS - 1))
                        rbState_q <= RB_START;
                RB_START:
                begin
                    rbState_q <= RB_DATA;
                    rbCnt_q   <= 5'h00;
                end
                RB_DATA:
                    if (rbCnt_q == 5'(`SCR_FRAME_BITS - 1))
                    begin
                        rbState_q <= RB_CHECK;
                        rbCnt_q   <= 5'h00;
                    end
                RB_CHECK:
                    if (rbCnt_q == 5'(`SCR_CHECK_BITS - 1))
                    begin
                        rbCnt_q   <= 5'h00;
                        rbFrame_q <= rbFrame_q + 2'h1;
                        rbState_q <= (rbFrame_q == 2'(`SCR_FRAMES - 1)) ? RB_END_START : RB_START;
                    end
                RB_END_START:
                begin
                    rbState_q <= RB_CRC;
                    rbCnt_q   <= 5'h00;
                end
                RB_CRC:
                    if (rbCnt_q == 5'(`SCR_CRC_W - 1))
                        rbState_q <= RB_LAST;
                RB_LAST:
                begin
                    rbState_q      <= RB_IDLE;
                    readbackActive <= 1'b0;
                end
                default:
                    rbState_q <= RB_IDLE;
            endcase
        end
    end

    // Signature covers frame start, data and check positions as sent
    always_ff @(posedge readbackShiftClk)
    begin
        if (rbRst_q || rbState_q == RB_IDLE)
            crc_q <= '0;
        else if (rbState_q == RB_CRC)
            crc_q <= {crc_q[`SCR_CRC_W-2:0], 1'b0};
        else if (rbState_q == RB_START || rbState_q == RB_DATA || rbState_q == RB_CHECK)
            crc_q <= {crc_q[`SCR_CRC_W-2:0], 1'b0} ^
                     ((crc_q[`SCR_CRC_W-1] ^ streamBit) ? `SCR_CRC_POLY : 11'h000);
    end

    // serial out is registered on readbackShiftClk
    always_ff @(posedge readbackShiftClk)
    begin
        if (rbRst_q)
            readbackSerialOut <= 1'b1;
        else
            readbackSerialOut <= streamBit;
    end

    a_active_rise: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        (rbState_q == RB_IDLE && readbackTrigger && cplSync_q) |=> readbackActive && rbState_q == RB_DUMMY)
        else $error("readback-active did not rise on next edge");
    a_dummy_start: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        $rose(readbackActive) |-> readbackSerialOut [*6] ##1 !readbackSerialOut)
        else $error("dummy bits or first start bit wrong");
    a_check_high: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        (rbState_q == RB_CHECK) |=> readbackSerialOut)
        else $error("error check position not high");
    a_forced_high: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        forced |=> readbackSerialOut)
        else $error("forced data position not high");
    a_data_polarity: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        (rbState_q == RB_DATA && !forced) |=> readbackSerialOut == $past(memBit))
        else $error("readback bit differs from loaded bit");
    a_crc_end: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        (rbState_q == RB_CRC && rbCnt_q == 5'h0a) |=> readbackActive ##1 !readbackActive)
        else $error("readback-active not dropped after signature");
    a_end_start: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        (rbState_q == RB_END_START) |=> !readbackSerialOut)
        else $error("final start bit not low");
    a_busy_hold: assert property (@(posedge readbackShiftClk) disable iff (rbRst_q)
        (rbState_q != RB_IDLE && rbState_q != RB_LAST) |=> readbackActive)
        else $error("readback aborted while in progress");
    c_rb_start: cover property (@(posedge readbackShiftClk) disable iff (rbRst_q) $rose(readbackActive));
    c_rb_end: cover property (@(posedge readbackShiftClk) disable iff (rbRst_q) $fell(readbackActive));

endmodule
`default_nettype wire

//--- bench/scr_ctrl_model.sv
// External controller model: test port master and init line holder
`timescale 1ns/10ps
`default_nettype none

module scr_ctrl_model (
    input  wire logic clk_sys,
    input  wire logic initOe,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      programN,
    output logic      initIn,
    output logic      readbackTrigger
);
    logic holdInitLow = 1'b1;

    // ==========================================================
    // Init line
    // wired low, pulled up
    assign initIn = ~(initOe | holdInitLow);

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        programN = 1'b1;
        readbackTrigger = 1'b0;
    end

    // ==========================================================
    // Test port cycles
    // one counted clock
    task automatic tckBit(input logic m, input logic d);
        @(negedge clk_sys);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk_sys);
        tck = 1'b1;
        repeat (4) @(negedge clk_sys);
        tck = 1'b0;
    endtask

    task automatic loadIr();
        for (int i = 0; i < 10; i++)
            tckBit(1'(10'h186 >> i), 1'(10'h0a0 >> i));
    endtask

    // Long pulses reconfigure, short ones are filtered
    task automatic pulseProgram(input int n);
        @(negedge clk_sys);
        programN = 1'b0;
        repeat (n) @(negedge clk_sys);
        programN = 1'b1;
    endtask
endmodule

`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for scan configuration load and readback
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam logic [63:0] MEM = 64'h0123_4567_89ab_cdef;
    localparam logic [23:0] LEN = 24'h00005b;
    logic clk_sys, rst, rbClk, tck, tms, tdi, programN, initIn, readbackTrigger;
    logic initOe, done, cfgComplete, readbackSerialOut, readbackActive;
    logic tdo, tdoOe, initOut;
    int   num_errors = 0;
    int   checks = 0;

    scr_ctrl_model partner (.clk_sys(clk_sys), .initOe(initOe), .tck(tck), .tms(tms), .tdi(tdi),
        .programN(programN), .initIn(initIn), .readbackTrigger(readbackTrigger));

    scr_config_readback DUT (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe), .programN(programN), .initIn(initIn), .initOut(initOut), .initOe(initOe), .done(done),
        .cfgComplete(cfgComplete), .readbackShiftClk(rbClk), .readbackTrigger(readbackTrigger),
        .readbackSerialOut(readbackSerialOut), .readbackActive(readbackActive));

    // ==========================================================
    // Clocks and reporting
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Odd start offset keeps the readback clock out of phase
    initial
    begin
        rbClk = 1'b0;
        #7;
        forever #15 rbClk = ~rbClk;
    end

    task automatic chk(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %b got %b", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic loadConfig();
        partner.loadIr();
        chk("tdoOe", 1'b0, tdoOe);
        partner.holdInitLow = 1'b0;
        repeat (10) @(negedge clk_sys);
        partner.tckBit(1'b1, 1'b0);
        partner.tckBit(1'b0, 1'b0);
        partner.tckBit(1'b0, 1'b0);
        for (int i = 0; i < 88; i++)
        begin
            if (i == 87)
            begin
                chk("done", 1'b0, done);
                chk("tdoOe", 1'b1, tdoOe);
                chk("tdo", 1'b0, tdo);
            end
            partner.tckBit(i == 87, (i < 24) ? LEN[23 - i] : MEM[i - 24]);
        end
        repeat (4) @(negedge clk_sys);
        chk("done", 1'b1, done);
        partner.tckBit(1'b1, 1'b0);
        partner.tckBit(1'b0, 1'b0);
        chk("complete", 1'b0, cfgComplete);
        partner.tckBit(1'b0, 1'b0);
        repeat (6) @(negedge clk_sys);
        chk("complete", 1'b1, cfgComplete);
    endtask

    task automatic readback();
        logic        q[$];
        logic [10:0] crc;
        logic        v;
        crc = 11'h000;
        repeat (5) q.push_back(1'b1);
        for (int f = 0; f < 4; f++)
            for (int b = -1; b < 20; b++)
            begin
                v = (b < 0) ? 1'b0 : (b > 15 || (f == 0 && b < 2) || (f == 3 && b > 8)) ? 1'b1 : MEM[f * 16 + b];
                q.push_back(v);
                crc = {crc[9:0], 1'b0} ^ ((crc[10] ^ v) ? 11'h205 : 11'h000);
            end
        q.push_back(1'b0);
        for (int k = 10; k >= 0; k--)
            q.push_back(crc[k]);
        repeat (10) @(negedge rbClk);
        partner.readbackTrigger = 1'b1;
        @(posedge rbClk);
        #1;
        chk("active", 1'b1, readbackActive);
        // A dropped trigger must not cut the stream short
        @(negedge rbClk);
        partner.readbackTrigger = 1'b0;
        foreach (q[k])
        begin
            @(posedge rbClk);
            #1;
            chk("serial", q[k], readbackSerialOut);
            chk("active", 1'b1, readbackActive);
        end
        @(posedge rbClk);
        #1;
        chk("active", 1'b0, readbackActive);
        chk("serial", 1'b1, readbackSerialOut);
    endtask

    task automatic reconfigure();
        partner.pulseProgram(10);
        repeat (4) @(negedge clk_sys);
        chk("done", 1'b1, done);
        partner.pulseProgram(20);
        chk("initOe", 1'b1, initOe);
        chk("initOut", 1'b0, initOut);
        chk("done", 1'b0, done);
    endtask

    initial
    begin
        rst = 1'b1;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        chk("initOe", 1'b1, initOe);
        repeat (60) @(negedge clk_sys);
        chk("initOe", 1'b0, initOe);
        loadConfig();
        readback();
        reconfigure();
        summarize();
    end
endmodule

`default_nettype wire
